/* File: olst_pkg.sv */
package olst_pkg;

    // Line indices, bit position in the output vector
    localparam int          OLST_NUM_LINES  = 10;
    localparam logic [3:0]  OLST_LINE_A1    = 4'h0;
    localparam logic [3:0]  OLST_LINE_A2    = 4'h1;
    localparam logic [3:0]  OLST_LINE_A4    = 4'h2;
    localparam logic [3:0]  OLST_LINE_B1    = 4'h3;
    localparam logic [3:0]  OLST_LINE_B2    = 4'h4;
    localparam logic [3:0]  OLST_LINE_B4    = 4'h5;
    localparam logic [3:0]  OLST_LINE_C1    = 4'h6;
    localparam logic [3:0]  OLST_LINE_C2    = 4'h7;
    localparam logic [3:0]  OLST_LINE_C4    = 4'h8;
    localparam logic [3:0]  OLST_LINE_D4    = 4'h9;
    localparam logic [3:0]  OLST_LINE_ALL   = 4'hA;
    localparam logic [3:0]  OLST_SEL_LAST   = 4'hA;

    // Timing
    localparam int          OLST_CLK_HZ     = 25000000;
    localparam int          OLST_DEBOUNCE_US = 10;
    localparam int          OLST_DEBOUNCE_CYC = OLST_CLK_HZ / 1000000 * OLST_DEBOUNCE_US;
    localparam int          OLST_SETTLE_US  = 2;
    localparam int          OLST_SETTLE_CYC = (OLST_CLK_HZ / 1000000) * OLST_SETTLE_US;
    localparam logic [1:0]  OLST_ALERT_EXITS = 2'h3;

    // Reset values
    localparam logic [9:0]  OLST_LINES_RST  = 10'h000;

    // Menu indicator codes on the display port
    typedef enum logic [2:0]
    {
        OLST_MENU_NONE     = 3'b000,
        OLST_MENU_OPTION   = 3'b001,
        OLST_MENU_SERVICE  = 3'b010
    } olst_menu_t;

    typedef enum logic [2:0]
    {
        OLST_ITEM_NONE     = 3'b000,
        OLST_ITEM_OTHER    = 3'b001,
        OLST_ITEM_TOGGLE   = 3'b010,
        OLST_ITEM_LOOPBACK = 3'b011
    } olst_item_t;

    typedef enum logic [1:0]
    {
        OLST_RES_NONE = 2'b00,
        OLST_RES_PASS = 2'b01,
        OLST_RES_FAIL = 2'b10
    } olst_result_t;

    typedef enum logic [3:0]
    {
        OLST_ST_NORMAL   = 4'b0000,
        OLST_ST_OPTION   = 4'b0001,
        OLST_ST_SERVICE  = 4'b0010,
        OLST_ST_BROWSE   = 4'b0011,
        OLST_ST_TOGGLE   = 4'b0100,
        OLST_ST_LOOP     = 4'b0101,
        OLST_ST_CHK0     = 4'b0110,
        OLST_ST_CHK1     = 4'b0111,
        OLST_ST_CHKZ     = 4'b1000
    } olst_state_t;

    // Operator controls, raw
    typedef struct packed
    {
        logic ack_button;
        logic alert_button;
        logic entry_button;
        logic set_cw;
        logic set_ccw;
    } olst_ctrl_t;

    // Display contents
    typedef struct packed
    {
        olst_menu_t   menu;
        olst_item_t   item;
        logic [3:0]   line;
        logic         line_valid;
        logic         state_digit;
        logic         state_valid;
        olst_result_t result;
    } olst_disp_t;

endpackage : olst_pkg

/* File: olst_service_test.sv */
// Overview of operation
// [R1] ACK held plus alert and entry: option menu
// [R2] One CCW detent in option: service menu
// [R3] Entry then rotate steps to toggle item
// [R4] Toggle entry selects D4, drives 1, displays
// [R5] Each ACK inverts selected line and digit
// [R6] Rotate picks line; all-lines toggles every line
// [R7] External side grounds strobe enable during toggling
// [R8] Three alert presses return to normal
// [R9] CW detent from toggle item shows loopback
// [R10] Loopback entry selects D4, displays name
// [R11] ACK runs drive0, drive1, strobe-off checks
// [R12] Pass if all three succeed, else fail
// [R13] Aux lines drive strobe and read back
// [R14] Rotate selects line; tester moves readback jumper
// [R15] Logic 1 low impedance, 0 high impedance
// [R16] Ten lines A1 through D4
// [R17] Every press and detent debounced, acted once
`timescale 1ns/10ps
`default_nettype none

module olst_debounce
    import olst_pkg::*;
#(
    parameter int DEBOUNCE_CYC = OLST_DEBOUNCE_CYC
)
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic raw,
    output logic      press
);
    logic [15:0] cnt_r;
    logic        stable_r;

    // Level must hold for the whole window before it counts
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r    <= 16'h0000;
            stable_r <= 1'b0;
            press    <= 1'b0;
        end
        else if (clk_en)
        begin
            press <= 1'b0;
            if (raw == stable_r)
                cnt_r <= 16'h0000;
            else if (cnt_r >= 16'(DEBOUNCE_CYC - 1))
            begin
                cnt_r    <= 16'h0000;
                stable_r <= raw;
                press    <= raw; // [R17]
            end
            else
                cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule : olst_debounce

module olst_service_test
    import olst_pkg::*;
#(
    parameter int DEBOUNCE_CYC = OLST_DEBOUNCE_CYC,
    parameter int SETTLE_CYC   = OLST_SETTLE_CYC
)
(
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire olst_ctrl_t       ctrl,
    input  wire logic             readback_in,
    output logic [9:0]            code_line_oe_n,
    output logic                  strobe_drive_test_line_o,
    output logic                  strobe_drive_test_line_oe_n,
    output logic                  service_active,
    output olst_disp_t            disp
);
    logic        rst_s1_r;
    logic        rst_n_r;
    logic        ack_p;
    logic        alert_p;
    logic        entry_p;
    logic        cw_p;
    logic        ccw_p;
    logic        ack_lvl_r;
    olst_state_t state_r;
    olst_item_t  item_r;
    logic [3:0]  sel_r;
    logic [9:0]  lines_r;
    logic [1:0]  alert_cnt_r;
    logic [7:0]  settle_r;
    logic        ok_r;
    olst_result_t result_r;
    logic [9:0]  sel_mask;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    olst_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_ack
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n_r),
        .clk_en  (clk_en),
        .raw     (ctrl.ack_button),
        .press   (ack_p)
    );
    olst_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_alert
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n_r),
        .clk_en  (clk_en),
        .raw     (ctrl.alert_button),
        .press   (alert_p)
    );
    olst_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_entry
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n_r),
        .clk_en  (clk_en),
        .raw     (ctrl.entry_button),
        .press   (entry_p)
    );
    olst_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_cw
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n_r),
        .clk_en  (clk_en),
        .raw     (ctrl.set_cw),
        .press   (cw_p)
    );
    olst_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_ccw
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n_r),
        .clk_en  (clk_en),
        .raw     (ctrl.set_ccw),
        .press   (ccw_p)
    );

    // Held level of ACK, tracked from its debounced press
    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            ack_lvl_r <= 1'b0;
        else if (clk_en)
        begin
            if (ack_p)
                ack_lvl_r <= 1'b1;
            else if (!ctrl.ack_button)
                ack_lvl_r <= 1'b0;
        end
    end

    assign sel_mask = (sel_r == OLST_LINE_ALL) ? 10'h3FF : (10'h001 << sel_r);

    // Menu and test sequencing
    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            state_r     <= OLST_ST_NORMAL;
            item_r      <= OLST_ITEM_NONE;
            sel_r       <= OLST_LINE_D4;
            lines_r     <= OLST_LINES_RST;
            alert_cnt_r <= 2'h0;
            settle_r    <= 8'h00;
            ok_r        <= 1'b0;
            result_r    <= OLST_RES_NONE;
            strobe_drive_test_line_o <= 1'b0;
        end
        else if (clk_en)
        begin
            if (alert_p && state_r != OLST_ST_NORMAL)
            begin
                if (alert_cnt_r == OLST_ALERT_EXITS - 2'h1)
                begin
                    state_r     <= OLST_ST_NORMAL; // [R8]
                    item_r      <= OLST_ITEM_NONE;
                    lines_r     <= OLST_LINES_RST;
                    alert_cnt_r <= 2'h0;
                    result_r    <= OLST_RES_NONE;
                    strobe_drive_test_line_o <= 1'b0;
                end
                else
                    alert_cnt_r <= alert_cnt_r + 2'h1;
            end
            else
            begin
                if (ack_p || entry_p || cw_p || ccw_p)
                    alert_cnt_r <= 2'h0;
                case (state_r)
                    OLST_ST_NORMAL:
                        // ACK must debounce at least one cycle before the later of alert and entry; their order is not checked
                        if (ack_lvl_r && ctrl.alert_button && ctrl.entry_button && (alert_p || entry_p))
                            state_r <= OLST_ST_OPTION; // [R1]
                    OLST_ST_OPTION:
                        if (ccw_p)
                            state_r <= OLST_ST_SERVICE; // [R2]
                    OLST_ST_SERVICE:
                        if (entry_p)
                        begin
                            state_r <= OLST_ST_BROWSE; // [R3]
                            item_r  <= OLST_ITEM_OTHER;
                        end
                    OLST_ST_BROWSE:
                    begin
                        if (cw_p || ccw_p)
                        begin
                            if (item_r == OLST_ITEM_TOGGLE && cw_p)
                                item_r <= OLST_ITEM_LOOPBACK; // [R9]
                            else if (item_r == OLST_ITEM_LOOPBACK && ccw_p)
                                item_r <= OLST_ITEM_TOGGLE;
                            else if (item_r == OLST_ITEM_OTHER)
                                item_r <= cw_p ? OLST_ITEM_TOGGLE : OLST_ITEM_LOOPBACK; // [R3]
                            else
                                item_r <= OLST_ITEM_OTHER;
                        end
                        else if (entry_p && item_r == OLST_ITEM_TOGGLE)
                        begin
                            state_r <= OLST_ST_TOGGLE;
                            sel_r   <= OLST_LINE_D4; // [R4]
                            lines_r <= 10'h001 << OLST_LINE_D4; // [R4] [R15]
                        end
                        else if (entry_p && item_r == OLST_ITEM_LOOPBACK)
                        begin
                            state_r  <= OLST_ST_LOOP;
                            sel_r    <= OLST_LINE_D4; // [R10]
                            result_r <= OLST_RES_NONE;
                        end
                    end
                    OLST_ST_TOGGLE:
                        // Strobe enable held grounded outside [R7]
                        if (ack_p)
                            lines_r <= lines_r ^ sel_mask; // [R5] [R6]
                        else if (cw_p)
                            sel_r <= (sel_r == OLST_SEL_LAST) ? 4'h0 : sel_r + 4'h1; // [R6]
                        else if (ccw_p)
                            sel_r <= (sel_r == 4'h0) ? OLST_SEL_LAST : sel_r - 4'h1; // [R6]
                    OLST_ST_LOOP:
                        if (ack_p)
                        begin
                            state_r  <= OLST_ST_CHK0; // [R11]
                            lines_r  <= OLST_LINES_RST;
                            strobe_drive_test_line_o <= 1'b1; // [R13]
                            settle_r <= 8'h00;
                            ok_r     <= 1'b1;
                            result_r <= OLST_RES_NONE;
                        end
                        else if (cw_p) // [R14]
                            sel_r <= (sel_r == OLST_LINE_D4) ? 4'h0 : sel_r + 4'h1;
                        else if (ccw_p)
                            sel_r <= (sel_r == 4'h0) ? OLST_LINE_D4 : sel_r - 4'h1;
                    OLST_ST_CHK0, OLST_ST_CHK1, OLST_ST_CHKZ:
                        // Wait lets the pin and jumper settle before sampling
                        if (settle_r < 8'(SETTLE_CYC - 1))
                            settle_r <= settle_r + 8'h01;
                        else
                        begin
                            settle_r <= 8'h00;
                            // Readback high means line released, low means pulled
                            if (state_r == OLST_ST_CHK0)
                            begin
                                ok_r    <= ok_r & readback_in; // [R11] [R13]
                                lines_r <= sel_mask;
                                state_r <= OLST_ST_CHK1;
                            end
                            else if (state_r == OLST_ST_CHK1)
                            begin
                                ok_r    <= ok_r & ~readback_in; // [R11]
                                strobe_drive_test_line_o <= 1'b0;
                                state_r <= OLST_ST_CHKZ;
                            end
                            else
                            begin
                                result_r <= (ok_r & readback_in) ? OLST_RES_PASS : OLST_RES_FAIL; // [R12]
                                lines_r  <= OLST_LINES_RST;
                                state_r  <= OLST_ST_LOOP;
                            end
                        end
                    default:
                        state_r <= OLST_ST_NORMAL;
                endcase
            end
        end
    end

    // Registered outputs; code line enable low means pin pulled low, strobe enable low drives strobe_drive_test_line_o (1)
    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            code_line_oe_n              <= 10'h3FF;
            strobe_drive_test_line_oe_n <= 1'b1;
            service_active              <= 1'b0;
            disp                        <= '0;
        end
        else if (clk_en)
        begin
            // Drive forced off only in the strobe-off check state OLST_ST_CHKZ
            code_line_oe_n <= ~(lines_r & {OLST_NUM_LINES{~(state_r == OLST_ST_CHKZ)}}); // [R15] [R16]
            strobe_drive_test_line_oe_n <= ~strobe_drive_test_line_o; // [R13]
            service_active <= (state_r != OLST_ST_NORMAL);
            disp.menu <= (state_r == OLST_ST_NORMAL) ? OLST_MENU_NONE :
                         (state_r == OLST_ST_OPTION) ? OLST_MENU_OPTION : OLST_MENU_SERVICE; // [R1] [R2]
            disp.item <= (state_r == OLST_ST_BROWSE) ? item_r :
                         (state_r == OLST_ST_TOGGLE) ? OLST_ITEM_TOGGLE :
                         (state_r >= OLST_ST_LOOP && state_r <= OLST_ST_CHKZ) ? OLST_ITEM_LOOPBACK : OLST_ITEM_NONE;
            disp.line <= sel_r;
            disp.line_valid  <= (state_r >= OLST_ST_TOGGLE && state_r <= OLST_ST_CHKZ);
            disp.state_digit <= (sel_r == OLST_LINE_ALL) ? lines_r[0] : lines_r[sel_r]; // [R5]
            disp.state_valid <= (state_r == OLST_ST_TOGGLE);
            disp.result      <= result_r; // [R12]
        end
    end

endmodule : olst_service_test
`default_nettype wire

/* File: olst_service_test_props.sv */
`timescale 1ns/10ps
`default_nettype none

module olst_service_test_props
    import olst_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic       clk_en,
    input wire logic [9:0] code_line_oe_n,
    input wire logic       strobe_drive_test_line_o,
    input wire logic       strobe_drive_test_line_oe_n,
    input wire logic       service_active,
    input wire olst_disp_t disp
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_idle_released;
        !service_active |-> code_line_oe_n == 10'h3FF;
    endproperty
    a_idle_released: assert property (p_idle_released) else $error("lines driven in normal mode");

    property p_exit_released;
        $fell(service_active) |-> code_line_oe_n == 10'h3FF && disp.menu == OLST_MENU_NONE;
    endproperty
    a_exit_released: assert property (p_exit_released) else $error("exit left lines driven");

    property p_option_menu;
        disp.menu != OLST_MENU_NONE |-> service_active;
    endproperty
    a_option_menu: assert property (p_option_menu) else $error("menu shown in normal mode");

    property p_digit;
        disp.state_valid |->
            disp.state_digit == !code_line_oe_n[(disp.line == OLST_LINE_ALL) ? 4'h0 : disp.line];
    endproperty
    a_digit: assert property (p_digit) else $error("state digit disagrees with pin");

    property p_strobe_oe;
        $rose(strobe_drive_test_line_o) |=> !strobe_drive_test_line_oe_n;
    endproperty
    a_strobe_oe: assert property (p_strobe_oe) else $error("strobe test line not driven");

    property p_one_line;
        strobe_drive_test_line_o |-> service_active && $countones(~code_line_oe_n) <= 1;
    endproperty
    a_one_line: assert property (p_one_line) else $error("more than one line under test");

    property p_strobe_span;
        $rose(strobe_drive_test_line_o) |-> strobe_drive_test_line_o [*3];
    endproperty
    a_strobe_span: assert property (p_strobe_span) else $error("strobe window too short");

    property p_result_due;
        $fell(strobe_drive_test_line_o) |-> ##[1:300] disp.result != OLST_RES_NONE;
    endproperty
    a_result_due: assert property (p_result_due) else $error("no loopback verdict");

    property p_freeze;
        !clk_en |=> $stable(disp) && $stable(code_line_oe_n);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule : olst_service_test_props

bind olst_service_test olst_service_test_props olst_service_test_props_inst
(
    .sys_clk                     (sys_clk),
    .reset_n                     (reset_n),
    .clk_en                      (clk_en),
    .code_line_oe_n              (code_line_oe_n),
    .strobe_drive_test_line_o    (strobe_drive_test_line_o),
    .strobe_drive_test_line_oe_n (strobe_drive_test_line_oe_n),
    .service_active              (service_active),
    .disp                        (disp)
);

`default_nettype wire

/* File: olst_jumper_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Strobe assumed grounded outside the loopback window
module olst_jumper_model
(
    input wire logic [9:0] code_line_oe_n,
    input wire logic [3:0] jumper_line,
    input wire logic       stuck_released,
    output logic           readback_in
);
    // Pull-up on readback; only the jumpered line can pull it low
    assign readback_in = stuck_released | code_line_oe_n[jumper_line];
endmodule : olst_jumper_model

`default_nettype wire

/* File: olst_service_test_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module olst_service_test_tb
    import olst_pkg::*;
;
    localparam int         DEB   = 4;
    localparam int         SET   = 3;
    localparam olst_ctrl_t ACK   = 5'h10;
    localparam olst_ctrl_t ALERT = 5'h08;
    localparam olst_ctrl_t ENTRY = 5'h04;
    localparam olst_ctrl_t CW    = 5'h02;
    localparam olst_ctrl_t CCW   = 5'h01;

    logic       sys_clk = 1'b0;
    logic       reset_n;
    logic       clk_en;
    olst_ctrl_t ctrl;
    logic       readback_in;
    logic [9:0] oe_n;
    logic       strobe_o;
    logic       strobe_oe_n;
    logic       service_active;
    olst_disp_t disp;
    logic [3:0] jumper;
    int         n_mismatch;
    int         samples_checked;

    always #20 sys_clk = ~sys_clk;

    olst_service_test #(.DEBOUNCE_CYC(DEB), .SETTLE_CYC(SET)) olst_service_test_inst
    (
        .sys_clk                     (sys_clk),
        .reset_n                     (reset_n),
        .clk_en                      (clk_en),
        .ctrl                        (ctrl),
        .readback_in                 (readback_in),
        .code_line_oe_n              (oe_n),
        .strobe_drive_test_line_o    (strobe_o),
        .strobe_drive_test_line_oe_n (strobe_oe_n),
        .service_active              (service_active),
        .disp                        (disp)
    );

    olst_jumper_model olst_jumper_model_inst
    (
        .code_line_oe_n (oe_n),
        .jumper_line    (jumper),
        .stuck_released (1'b0),
        .readback_in    (readback_in)
    );

    task stop_test();
        $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            n_mismatch++;
        end
    endtask : check

    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    // Hold each level a full window so both edges are taken
    task drive(input olst_ctrl_t v);
        @(posedge sys_clk);
        ctrl <= v;
        cyc(DEB + 4);
    endtask : drive

    task press(input olst_ctrl_t v);
        drive(v);
        drive('0);
    endtask : press

    task to_toggle_item();
        drive(ACK);
        drive(ACK | ALERT | ENTRY);
        drive('0);
        check(disp.menu, OLST_MENU_OPTION);
        check(service_active, 1'b1);
        press(CCW);
        check(disp.menu, OLST_MENU_SERVICE);
        press(ENTRY);
        press(CW);
        check(disp.item, OLST_ITEM_TOGGLE);
    endtask : to_toggle_item

    task leave();
        repeat (3) press(ALERT);
        check(service_active, 1'b0);
        check(oe_n, 10'h3FF);
    endtask : leave

    // Verdict only read after the strobe window has closed
    task run_check(input olst_result_t exp);
        int i;
        @(posedge sys_clk);
        ctrl <= ACK;
        for (i = 0; i < 80 && strobe_o !== 1'b1; i++) cyc(1);
        cyc(1);
        check(strobe_oe_n, 1'b0);
        for (i = 0; i < 80 && strobe_o !== 1'b0; i++) cyc(1);
        cyc(SET + 6);
        drive('0);
        check(disp.result, exp);
        check(oe_n, 10'h3FF);
        check(strobe_oe_n, 1'b1);
    endtask : run_check

    task t_reset();
        check(oe_n, 10'h3FF);
        check(service_active, 1'b0);
        check({disp.menu, disp.item, disp.line_valid, disp.state_valid, disp.result}, 16'h0000);
        $display("t_reset done");
    endtask : t_reset

    task t_toggle();
        to_toggle_item();
        press(ENTRY);
        check(oe_n, 10'h1FF);
        check(disp.line, OLST_LINE_D4);
        check(disp.state_digit, 1'b1);
        press(ACK);
        check(oe_n, 10'h3FF);
        check(disp.state_digit, 1'b0);
        @(posedge sys_clk);
        ctrl <= ACK;
        cyc(DEB - 2);
        drive('0);
        check(oe_n, 10'h3FF);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        press(ACK);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        cyc(DEB + 4);
        check(oe_n, 10'h3FF);
        press(CW);
        check(disp.line, OLST_LINE_ALL);
        press(ACK);
        check(oe_n, 10'h000);
        press(CCW);
        check(disp.line, OLST_LINE_D4);
        press(ACK);
        check(oe_n, 10'h200);
        leave();
        $display("t_toggle done");
    endtask : t_toggle

    task t_loop();
        to_toggle_item();
        press(CW);
        check(disp.item, OLST_ITEM_LOOPBACK);
        press(ENTRY);
        check(disp.line, OLST_LINE_D4);
        check(disp.line_valid, 1'b1);
        jumper <= 4'h9;
        run_check(OLST_RES_PASS);
        press(CW);
        check(disp.line, OLST_LINE_A1);
        jumper <= 4'h0;
        run_check(OLST_RES_PASS);
        press(CCW);
        check(disp.line, OLST_LINE_D4);
        run_check(OLST_RES_FAIL);
        leave();
        $display("t_loop done");
    endtask : t_loop

    initial
    begin
        #200000;
        n_mismatch++;
        stop_test();
    end

    initial
    begin
        reset_n         = 1'b0;
        clk_en          = 1'b1;
        ctrl            = '0;
        jumper          = 4'h9;
        n_mismatch      = 0;
        samples_checked = 0;
        cyc(2);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        cyc(4);
        t_reset();
        t_toggle();
        t_loop();
        stop_test();
    end
endmodule : olst_service_test_tb

`default_nettype wire
